// ### logic/hpl_pkg.sv
// constants of the host-port lock and page-select registers.
// assumes an spi engine outside that hands over one byte access at a time.
package hpl_pkg;
   localparam int          HPL_DATA_W       = 8;
   localparam int          HPL_PAGE_W       = 8;
   localparam int          HPL_OFFSET_W     = 7;
   localparam int          HPL_ADDR_W       = HPL_PAGE_W + HPL_OFFSET_W;
   localparam int          HPL_PAGE_BYTES   = 128;
   localparam logic [14:0] HPL_CTRL_ADDR    = 15'h037e;
   localparam logic [14:0] HPL_PAGESEL_ADDR = 15'h037f;
   localparam int          HPL_LOCK_BIT     = 7;
   localparam int          HPL_STATUS_BIT   = 0;
   localparam logic [7:0]  HPL_CTRL_RESET   = 8'h00;
   localparam logic [7:0]  HPL_PAGE_RESET   = 8'h00;
   localparam logic [7:0]  HPL_RSVD_PAGE_A  = 8'h07;
   localparam logic [7:0]  HPL_RSVD_PAGE_B  = 8'h09;
   localparam logic [7:0]  HPL_RSVD_FIRST   = 8'h0e;
   localparam int          HPL_READ_LATENCY = 2;
endpackage

// ### logic/hpl_access_if.sv
// decode signals between the register bank and its page decoder.
// assumes both ends run on the same clock; the decode is combinational.
`timescale 1ns/1ns
interface hpl_access_if;
   logic [7:0]  page;
   logic [6:0]  offset;
   logic [14:0] fullAddr;
   logic        pageReserved;
   logic        hitControl;
   logic        hitPageSel;

   modport decoder (
      input  page,
      input  offset,
      output fullAddr,
      output pageReserved,
      output hitControl,
      output hitPageSel
   );
   modport bank (
      output page,
      output offset,
      input  fullAddr,
      input  pageReserved,
      input  hitControl,
      input  hitPageSel
   );
endinterface

// ### logic/hpl_page_decode.sv
// page decoder: joins page number and in-page offset into a device address.
// assumes the bank drives page and offset from its own registers and inputs.
`timescale 1ns/1ns
module hpl_page_decode (
   hpl_access_if.decoder acc
);
   function automatic logic isReservedPage(input logic [7:0] pg);
      isReservedPage = (pg == hpl_pkg::HPL_RSVD_PAGE_A) ||
                       (pg == hpl_pkg::HPL_RSVD_PAGE_B) ||
                       (pg >= hpl_pkg::HPL_RSVD_FIRST);
   endfunction

   // page n covers bytes n*128 .. n*128+127, so the page is the upper bits
   assign acc.fullAddr     = {acc.page, acc.offset};
   assign acc.pageReserved = isReservedPage(acc.page);
   // both housekeeping bytes answer on every page, else page 0 could never leave
   assign acc.hitControl   = (acc.offset == hpl_pkg::HPL_CTRL_ADDR[6:0]);
   assign acc.hitPageSel   = (acc.offset == hpl_pkg::HPL_PAGESEL_ADDR[6:0]);
endmodule

// ### logic/hpl_host_port_regs.sv
// host-port housekeeping bank: lockout, access status and page select.
// assumes the spi engine presents one byte access per strobe, synchronous to core_clk,
// and that the device register space answers devRdData in the same cycle that devRdStb is high.
`timescale 1ns/1ns
module hpl_host_port_regs #(
   parameter int DATA_W   = hpl_pkg::HPL_DATA_W,
   parameter int OFFSET_W = hpl_pkg::HPL_OFFSET_W,
   parameter int ADDR_W   = hpl_pkg::HPL_ADDR_W
) (
   input  wire logic                core_clk,
   input  wire logic                rst,
   input  wire logic [OFFSET_W-1:0] hostOffset,
   input  wire logic                hostWrStb,
   input  wire logic                hostRdStb,
   input  wire logic [DATA_W-1:0]   hostWrData,
   input  wire logic                hostFail,
   input  wire logic [DATA_W-1:0]   devRdData,
   output logic      [DATA_W-1:0]   rdData,
   output logic                     rdValid,
   output logic      [ADDR_W-1:0]   devAddr,
   output logic                     devWrStb,
   output logic                     devRdStb,
   output logic      [DATA_W-1:0]   devWrData,
   output logic      [7:0]          pageSelect,
   output logic                     lockoutActive,
   output logic                     accessFailed
);
   typedef enum logic [1:0] {
      HPL_SRC_NONE,
      HPL_SRC_CTRL,
      HPL_SRC_PAGE,
      HPL_SRC_DEV
   } hpl_src_type;

   hpl_access_if acc ();

   logic              lock_reg;
   logic              status_reg;
   logic [7:0]        page_reg;
   logic [ADDR_W-1:0] devAddr_reg;
   logic              devWrStb_reg;
   logic              devRdStb_reg;
   logic [DATA_W-1:0] devWrData_reg;
   hpl_src_type       src_reg;
   logic [DATA_W-1:0] rdData_reg;
   logic              rdValid_reg;

   logic              isWrite;
   logic              isRead;
   logic              access;
   logic              localHit;
   logic              blockedWrite;
   logic              failNow;
   logic              ctrlWrOk;
   logic              pageWrOk;
   logic [DATA_W-1:0] ctrlView;
   hpl_src_type       src_next;

   hpl_page_decode u_decode (
      .acc (acc)
   );

   // a local byte takes a write only when addressed, allowed and not broken
   function automatic logic localWrite(input logic wr, input logic hit, input logic allowed, input logic fail);
      localWrite = wr && hit && allowed && !fail;
   endfunction

   assign acc.page   = page_reg;
   assign acc.offset = hostOffset;

   // a write and a read in the same cycle is taken as the write only
   assign isWrite  = hostWrStb;
   assign isRead   = hostRdStb && !hostWrStb;
   assign access   = isWrite || isRead;
   assign localHit = acc.hitControl || acc.hitPageSel;

   // control stays writable under lock, otherwise the lock could never be lifted
   assign blockedWrite = isWrite && lock_reg && !acc.hitControl;

   // reserved pages reach no paged register, so an access there other than to 0x7e/0x7f counts as failed
   assign failNow = hostFail || blockedWrite || (!localHit && acc.pageReserved);

   // write acceptance of the two local bytes
   assign ctrlWrOk = localWrite(isWrite, acc.hitControl, 1'b1, hostFail);
   assign pageWrOk = localWrite(isWrite, acc.hitPageSel, !lock_reg, hostFail);

   // failure shows the lock too; success reads back clean zeros
   always_comb begin
      ctrlView = '0;
      if (status_reg) begin
         ctrlView[hpl_pkg::HPL_STATUS_BIT] = 1'b1;
         ctrlView[hpl_pkg::HPL_LOCK_BIT]   = lock_reg;
      end
   end

   always_comb begin
      src_next = HPL_SRC_NONE;
      if (isRead) begin
         if (acc.hitControl) begin
            src_next = HPL_SRC_CTRL;
         end else if (acc.hitPageSel) begin
            src_next = HPL_SRC_PAGE;
         end else if (!failNow) begin
            src_next = HPL_SRC_DEV;
         end
      end
   end

   // lockout bit of the control register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         lock_reg <= hpl_pkg::HPL_CTRL_RESET[hpl_pkg::HPL_LOCK_BIT];
      end else if (ctrlWrOk) begin
         lock_reg <= hostWrData[hpl_pkg::HPL_LOCK_BIT];
      end
   end

   // status tracks the outcome of the latest access, good or bad
   always_ff @(posedge core_clk) begin
      if (rst) begin
         status_reg <= hpl_pkg::HPL_CTRL_RESET[hpl_pkg::HPL_STATUS_BIT];
      end else if (access) begin
         status_reg <= failNow;
      end
   end

   // page select; a reserved value is stored as written, the host must avoid it
   always_ff @(posedge core_clk) begin
      if (rst) begin
         page_reg <= hpl_pkg::HPL_PAGE_RESET;
      end else if (pageWrOk) begin
         page_reg <= hostWrData;
      end
   end

   // forwarded write strobe into the paged register space
   always_ff @(posedge core_clk) begin
      if (rst) begin
         devWrStb_reg <= 1'b0;
      end else begin
         devWrStb_reg <= isWrite && !localHit && !failNow;
      end
   end

   // write data holds until the next write, so the far side may take it late
   always_ff @(posedge core_clk) begin
      if (rst) begin
         devWrData_reg <= '0;
      end else if (isWrite) begin
         devWrData_reg <= hostWrData;
      end
   end

   // forwarded read into the paged register space
   always_ff @(posedge core_clk) begin
      if (rst) begin
         devRdStb_reg <= 1'b0;
      end else begin
         devRdStb_reg <= (src_next == HPL_SRC_DEV);
      end
   end

   // address moves on local accesses too; without a strobe the far side ignores it
   always_ff @(posedge core_clk) begin
      if (rst) begin
         devAddr_reg <= '0;
      end else if (access) begin
         devAddr_reg <= acc.fullAddr;
      end
   end

   // read source, one cycle behind the request
   always_ff @(posedge core_clk) begin
      if (rst) begin
         src_reg <= HPL_SRC_NONE;
      end else if (!isRead) begin
         src_reg <= HPL_SRC_NONE;
      end else if (src_next == HPL_SRC_NONE) begin
         // a refused paged read answers with the control view
         src_reg <= HPL_SRC_CTRL;
      end else begin
         src_reg <= src_next;
      end
   end

   // read answer: fixed two-cycle latency for every address
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdValid_reg <= 1'b0;
      end else begin
         rdValid_reg <= (src_reg != HPL_SRC_NONE);
      end
   end

   // a failed read of the paged space returns the control view, which flags the fault.
   // the last answer stays put so a slow host may still pick it up
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdData_reg <= '0;
      end else begin
         unique case (src_reg)
            HPL_SRC_NONE: rdData_reg <= rdData_reg;
            HPL_SRC_CTRL: rdData_reg <= ctrlView;
            HPL_SRC_PAGE: rdData_reg <= page_reg;
            HPL_SRC_DEV:  rdData_reg <= devRdData;
         endcase
      end
   end

   // every output is a flop, nothing combinational reaches a pin,
   // so the spi engine and the far side see clean edges only
   assign rdData        = rdData_reg;
   assign rdValid       = rdValid_reg;
   assign devAddr       = devAddr_reg;
   assign devWrStb      = devWrStb_reg;
   assign devRdStb      = devRdStb_reg;
   assign devWrData     = devWrData_reg;
   assign pageSelect    = page_reg;
   assign lockoutActive = lock_reg;
   assign accessFailed  = status_reg;
endmodule

// ### bench/hpl_checker.sv
// checker: timing relations on the host-port bank ports.
// assumes it is bound onto hpl_host_port_regs.
`timescale 1ns/1ns
module hpl_checker (
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic [6:0]  hostOffset,
   input wire logic        hostWrStb,
   input wire logic        hostRdStb,
   input wire logic [7:0]  hostWrData,
   input wire logic        hostFail,
   input wire logic [7:0]  rdData,
   input wire logic        rdValid,
   input wire logic [14:0] devAddr,
   input wire logic        devWrStb,
   input wire logic        devRdStb,
   input wire logic [7:0]  pageSelect,
   input wire logic        lockoutActive,
   input wire logic        accessFailed
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff rst;
   // 0x7e/0x7f answer on every page
   wire logic isLocal = hostOffset[6:1] == 6'h3f;
   wire logic pageOk  = pageSelect < 8'h0e && pageSelect != 8'h07 && pageSelect != 8'h09;
   wire logic anyAcc  = hostWrStb || hostRdStb;
   sequence s_rd; hostRdStb && !hostWrStb && !hostFail; endsequence
   sequence s_ctrl_rd; s_rd ##0 (hostOffset == 7'h7e); endsequence
   property p_locked; hostWrStb && lockoutActive && hostOffset != 7'h7e
      |=> !devWrStb && $stable(pageSelect) && accessFailed; endproperty
   a_locked: assert property (p_locked) else $error("locked write took effect");
   property p_open; hostWrStb && !lockoutActive && !hostFail && hostOffset == 7'h7f
      |=> pageSelect == $past(hostWrData) && !accessFailed; endproperty
   a_open: assert property (p_open) else $error("open page write lost");
   property p_fail; anyAcc && hostFail |=> accessFailed; endproperty
   a_fail: assert property (p_fail) else $error("failed access not flagged");
   property p_ctrl_zero; s_ctrl_rd |-> ##2 rdValid && rdData == 8'h00; endproperty
   a_ctrl_zero: assert property (p_ctrl_zero) else $error("control not zero after success");
   property p_paged_rd; s_rd ##0 (!isLocal && pageOk)
      |=> (devRdStb && devAddr == {$past(pageSelect), $past(hostOffset)}) ##1 rdValid; endproperty
   a_paged_rd: assert property (p_paged_rd) else $error("paged read address wrong");
   property p_rsvd; anyAcc && !isLocal && !pageOk |=> !devRdStb && !devWrStb && accessFailed; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved page reached space");
   property p_reset; $fell(rst) |-> pageSelect == 8'h00 && !lockoutActive && !accessFailed; endproperty
   a_reset: assert property (p_reset) else $error("bad state after reset");
endmodule
bind hpl_host_port_regs hpl_checker i_chk (.core_clk(core_clk), .rst(rst), .hostOffset(hostOffset),
   .hostWrStb(hostWrStb), .hostRdStb(hostRdStb), .hostWrData(hostWrData), .hostFail(hostFail),
   .rdData(rdData), .rdValid(rdValid), .devAddr(devAddr), .devWrStb(devWrStb), .devRdStb(devRdStb),
   .pageSelect(pageSelect), .lockoutActive(lockoutActive), .accessFailed(accessFailed));

// ### bench/hpl_dev_space.sv
// model of the paged register space behind the bank.
// assumes devRdData is taken while devRdStb is high.
`timescale 1ns/1ns
module hpl_dev_space #(
   parameter logic [7:0] KEY = 8'ha5
) (
   input  wire logic        core_clk,
   input  wire logic        devRdStb,
   input  wire logic [14:0] devAddr,
   output logic      [7:0]  devRdData
);
   logic [7:0] junk = 8'h00;
   always @(posedge core_clk) junk <= junk + 8'h3b;
   // noise outside a read, so a held value cannot pass
   assign devRdData = devRdStb ? devAddr[7:0] ^ KEY : junk;
endmodule

// ### bench/host_port_lock_and_page_select_bench.sv
// testbench: host accesses to lock, status and page select.
// assumes hpl_dev_space stands for the paged space.
`timescale 1ns/1ns
module host_port_lock_and_page_select_bench;
   localparam logic [7:0] KEY = 8'ha5;
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic        hostWrStb = 1'b0;
   logic        hostRdStb = 1'b0;
   logic        hostFail = 1'b0;
   logic [6:0]  hostOffset = 7'h00;
   logic [7:0]  hostWrData = 8'h00;
   logic [7:0]  devRdData, rdData, devWrData, pageSelect, d;
   logic [14:0] devAddr;
   logic        rdValid, devWrStb, devRdStb, lockoutActive, accessFailed;
   int          err_total = 0;
   int          samples_checked = 0;
   hpl_host_port_regs i_dut (.core_clk(core_clk), .rst(rst), .hostOffset(hostOffset), .hostWrStb(hostWrStb),
      .hostRdStb(hostRdStb), .hostWrData(hostWrData), .hostFail(hostFail), .devRdData(devRdData),
      .rdData(rdData), .rdValid(rdValid), .devAddr(devAddr), .devWrStb(devWrStb), .devRdStb(devRdStb),
      .devWrData(devWrData), .pageSelect(pageSelect), .lockoutActive(lockoutActive),
      .accessFailed(accessFailed));
   hpl_dev_space #(.KEY(KEY)) i_dev (.core_clk(core_clk), .devRdStb(devRdStb), .devAddr(devAddr),
      .devRdData(devRdData));
   initial begin
      forever #20 core_clk = ~core_clk;
   end
   task automatic chk(input logic [14:0] got, input logic [14:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [6:0] off, input logic [7:0] dat, input logic f);
      @(posedge core_clk);
      hostWrStb <= 1'b1;
      hostOffset <= off;
      hostWrData <= dat;
      hostFail <= f;
      @(posedge core_clk);
      hostWrStb <= 1'b0;
      hostFail <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [6:0] off);
      @(posedge core_clk);
      hostRdStb <= 1'b1;
      hostOffset <= off;
      @(posedge core_clk);
      hostRdStb <= 1'b0;
      @(posedge core_clk);
      #1;
      chk({14'h0, rdValid}, 15'h1);
      d = rdData;
   endtask
   task automatic end_of_test();
      $display("checks=%0d errors=%0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (4000) @(posedge core_clk);
      err_total++;
      $display("watchdog expired");
      end_of_test();
   end
   initial begin
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      #1;
      chk({7'h0, pageSelect}, 15'h0);
      chk({13'h0, accessFailed, lockoutActive}, 15'h0);
      $display("test reset done");
      wr(7'h7f, 8'h06, 1'b0);
      chk({7'h0, pageSelect}, 15'h6);
      rd(7'h7f);
      chk({7'h0, d}, 15'h6);
      rd(7'h45);
      chk({7'h0, d}, {7'h0, 8'h45 ^ KEY});
      chk(devAddr, 15'h0345);
      wr(7'h10, 8'h5a, 1'b0);
      chk({6'h0, devWrStb, devWrData}, 15'h15a);
      $display("test paging done");
      wr(7'h45, 8'h11, 1'b1);
      chk({14'h0, accessFailed}, 15'h1);
      rd(7'h7e);
      chk({6'h0, accessFailed, d}, 15'h0);
      $display("test status done");
      for (int i = 0; i < 4; i++) begin
         wr(7'h7f, i == 0 ? 8'h07 : i == 1 ? 8'h09 : i == 2 ? 8'h0e : 8'hff, 1'b0);
         rd(7'h20);
         chk({6'h0, accessFailed, d}, 15'h101);
      end
      $display("test reserved pages done");
      wr(7'h7f, 8'h08, 1'b0);
      wr(7'h7e, 8'h80, 1'b0);
      chk({14'h0, lockoutActive}, 15'h1);
      wr(7'h7f, 8'h03, 1'b0);
      chk({6'h0, accessFailed, pageSelect}, 15'h108);
      wr(7'h10, 8'h33, 1'b0);
      chk({14'h0, devWrStb}, 15'h0);
      wr(7'h7e, 8'h00, 1'b0);
      wr(7'h7f, 8'h0e, 1'b0);
      wr(7'h7e, 8'h80, 1'b0);
      rd(7'h20);
      chk({6'h0, accessFailed, d}, 15'h181);
      wr(7'h7e, 8'h00, 1'b0);
      wr(7'h7f, 8'h03, 1'b0);
      chk({7'h0, pageSelect}, 15'h3);
      $display("test lockout done");
      @(posedge core_clk);
      hostWrStb <= 1'b1;
      hostRdStb <= 1'b1;
      hostOffset <= 7'h7f;
      hostWrData <= 8'h05;
      @(posedge core_clk);
      hostWrStb <= 1'b0;
      hostRdStb <= 1'b0;
      @(posedge core_clk);
      #1;
      chk({6'h0, rdValid, pageSelect}, 15'h005);
      $display("test write beats read done");
      end_of_test();
   end
endmodule
